//--- cmtps_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cmtps_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        sixth_clock_phase_i,
  input wire logic        mem_start_o,
  input wire logic        mem_write_o,
  input wire logic [11:0] mem_addr_o,
  input wire logic [47:0] mem_wdata_o,
  input wire logic        mem_wparity_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_BUSY_SPAN: assert property (mem_start_o |-> busy_o [*3])
    else $error("cycle too short");
  AST_START_PULSE: assert property (mem_start_o |=> !mem_start_o [*3])
    else $error("start pulse spacing");
  AST_TRIGGER: assert property (mem_start_o && !$past(busy_o) |-> $past(sixth_clock_phase_i))
    else $error("start without phase");
  AST_CYCLE_HOLD: assert property (mem_start_o |=> ($stable(mem_addr_o) && $stable(mem_write_o)) [*2])
    else $error("address moved in cycle");
  AST_PARITY: assert property (mem_start_o && mem_write_o |=> ##1 mem_wparity_o == (~^mem_wdata_o))
    else $error("write parity");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  cover property (mem_start_o && !mem_write_o);
  cover property (mem_start_o && mem_write_o);
  cover property (wb_ack_o);
endmodule
bind cmtps_core cmtps_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .sixth_clock_phase_i, .mem_start_o, .mem_write_o, .mem_addr_o, .mem_wdata_o,
  .mem_wparity_o, .busy_o);
`default_nettype wire

//--- cmtps_consts.vh
`ifndef CMTPS_CONSTS_VH
`define CMTPS_CONSTS_VH
`define CMTPS_DATA_W       48
`define CMTPS_ADDR_W       12
`define CMTPS_GROUPS       6
`define CMTPS_REG_CTRL     3'h0
`define CMTPS_REG_INFO_LO  3'h1
`define CMTPS_REG_INFO_HI  3'h2
`define CMTPS_REG_STATUS   3'h3
`define CMTPS_REG_ADDR     3'h4
`define CMTPS_CTRL_RST     32'h0000_2040
`define CMTPS_CB_UNIFORM   0
`define CMTPS_CB_MANUAL    1
`define CMTPS_CB_WORST     2
`define CMTPS_CB_SINGLE    3
`define CMTPS_CB_STOP_ERR  4
`define CMTPS_CB_STOP_FIN  5
`define CMTPS_CB_WORD_TRUE 6
`define CMTPS_CB_BITC_LO   7
`define CMTPS_CB_BITC_HI   12
`define CMTPS_CB_COUNT     13
`define CMTPS_CB_MAN_WR    14
`define CMTPS_SB_ERR       20
`define CMTPS_PH_IDLE      2'h0
`define CMTPS_PH_ONE       2'h1
`define CMTPS_PH_SAMPLE    2'h2
`define CMTPS_PH_END       2'h3
`define CMTPS_CHK_BIT_A    2
`define CMTPS_CHK_BIT_B    8
`define CMTPS_ODD_PARITY   1'b1
`endif

//--- cmtps_core.v
// Notes on behaviour
// - read cycle compares, restores, address held
// - write cycle writes pattern, address then advances
// - each address visited twice per two-cycle pass
// - worst-case select gives four cycles per address
// - second cycle writes complement, address held
// - third cycle reads against complement, address held
// - fourth cycle writes true pattern, address advances
// - fill stops at last address, counter three
// - uniform automatic: same word everywhere, word-complement
// - uniform automatic uses same two/four sequencing
// - manual mode writes info word with parity
// - manual ignores worst-case; writes or reads repeat
// - manual writes never clear the info word
// - manual reads clear info unless error stopped
// - stop-on-error halts cycles on read fault: parity in manual, data compare in auto
// - start record set at count three, enables advance
// - button latch plus synchroniser: one-pulse start
// - trigger needs start pulse, sixth phase, count zero
// - single mode: flag set, counter forced zero
// - each later press runs one cycle, clears flag
// - continuous: count three two pulses, then restart
// - write flag toggles each cycle for auto patterns
// - checker bit is xor of address bits 2, 8
// - worst-case flag spans second and third cycles
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`include "cmtps_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module cmtps_core (
  input  wire                       clk_i,
  input  wire                       rst_i,
  input  wire                       wb_cyc_i,
  input  wire                       wb_stb_i,
  input  wire                       wb_we_i,
  input  wire [4:0]                 wb_adr_i,
  input  wire [3:0]                 wb_sel_i,
  input  wire [31:0]                wb_dat_i,
  output reg  [31:0]                wb_dat_o,
  output reg                        wb_ack_o,
  input  wire                       start_button_level_i,
  input  wire                       start_gating_qualifier_i,
  input  wire                       sixth_clock_phase_i,
  input  wire [`CMTPS_DATA_W-1:0]   mem_rdata_i,
  input  wire                       mem_rparity_i,
  output reg                        mem_start_o,
  output reg                        mem_write_o,
  output reg  [`CMTPS_ADDR_W-1:0]   mem_addr_o,
  output reg  [`CMTPS_DATA_W-1:0]   mem_wdata_o,
  output reg                        mem_wparity_o,
  output wire                       busy_o
);

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  function parity;
    input [`CMTPS_DATA_W-1:0] w;
    begin
      parity = (^w) ^ `CMTPS_ODD_PARITY;
    end
  endfunction

  function [`CMTPS_ADDR_W-1:0] next_addr;
    input [`CMTPS_ADDR_W-1:0] cur;
    input                     step;
    begin
      if (step)
        next_addr = cur + 1'b1;
      else
        next_addr = cur;
    end
  endfunction

  function [31:0] status_word;
    input                     err;
    input                     adv;
    input                     wcf;
    input                     wrf;
    input                     srf;
    input                     ehf;
    input [1:0]               phv;
    input [`CMTPS_ADDR_W-1:0] adr;
    begin
      status_word                    = 32'h0000_0000;
      status_word[`CMTPS_ADDR_W-1:0] = adr;
      status_word[13:12]             = phv;
      status_word[14]                = ehf;
      status_word[15]                = srf;
      status_word[16]                = wrf;
      status_word[17]                = wcf;
      status_word[18]                = adv;
      status_word[19]                = err;
    end
  endfunction

  reg  [31:0]               ctrl_q;
  reg  [`CMTPS_DATA_W-1:0]  info_hold_register_q;
  reg  [`CMTPS_ADDR_W-1:0]  word_address_counter_q;
  reg  [1:0]                cycle_phase_counter_q;
  reg                       end_hold_q;
  reg                       start_record_flag_q;
  reg                       write_cycle_flag_q;
  reg                       worst_case_flag_q;
  reg                       advance_pending_q;
  reg                       error_q;
  reg                       start_latch_out_q;
  reg                       sync1_q;
  reg                       sync2_q;
  reg                       sync2_prev_q;
  reg                       start_pulse_level_q;

  wire        uniform_sel   = ctrl_q[`CMTPS_CB_UNIFORM];
  wire        manual_mode   = uniform_sel & ctrl_q[`CMTPS_CB_MANUAL];
  wire        worst_sel     = ctrl_q[`CMTPS_CB_WORST] & ~manual_mode;
  wire        single_sel    = ctrl_q[`CMTPS_CB_SINGLE];
  wire        stop_err_sel  = ctrl_q[`CMTPS_CB_STOP_ERR];
  wire        stop_fin_sel  = ctrl_q[`CMTPS_CB_STOP_FIN];
  wire        word_true     = ctrl_q[`CMTPS_CB_WORD_TRUE];
  wire [5:0]  bit_comp      = ctrl_q[`CMTPS_CB_BITC_HI:`CMTPS_CB_BITC_LO];
  wire        count_en      = ctrl_q[`CMTPS_CB_COUNT];
  wire        man_wr        = ctrl_q[`CMTPS_CB_MAN_WR];

  wire [1:0]  ph            = cycle_phase_counter_q;
  wire        phase_low_bit = ph[0];
  wire        phase_high_bit = ph[1];
  wire        stopped_err   = stop_err_sel & error_q;
  wire        last_addr     = &word_address_counter_q;
  wire        final_stop    = stop_fin_sel & last_addr &
                              (manual_mode | (write_cycle_flag_q & ~worst_case_flag_q));
  wire        continue_enable = ~single_sel & ~stopped_err & ~final_stop;
  // one-clock start pulse, sixth phase and both counter bits clear
  wire        trig_idle     = start_pulse_level_q & sixth_clock_phase_i &
                              ~phase_low_bit & ~phase_high_bit;
  wire        at_end        = (ph == `CMTPS_PH_END) & ~end_hold_q;
  wire        trig_cont     = (ph == `CMTPS_PH_END) & end_hold_q;
  wire        cycle_start   = trig_idle | trig_cont;
  wire        write_now     = manual_mode ? man_wr : write_cycle_flag_q;
  // address step taken at the start of the next cycle
  wire        addr_step     = cycle_start & start_record_flag_q &
                              advance_pending_q & count_en;
  wire [`CMTPS_ADDR_W-1:0] addr_d = next_addr(word_address_counter_q, addr_step);

  // pattern generation
  reg  [`CMTPS_DATA_W-1:0]  pattern;
  reg                       base_bit;
  integer                   i;
  always @*
  begin
    base_bit = uniform_sel ? 1'b1 :
               (word_address_counter_q[`CMTPS_CHK_BIT_A] ^
                word_address_counter_q[`CMTPS_CHK_BIT_B]);
    base_bit = base_bit ^ ~word_true ^ worst_case_flag_q;
    for (i = 0; i < `CMTPS_DATA_W; i = i + 1)
      pattern[i] = base_bit ^ bit_comp[i % `CMTPS_GROUPS];
  end

  wire read_fault = manual_mode ? (parity(mem_rdata_i) != mem_rparity_i) :
                                  (mem_rdata_i != pattern);

  // start button latch and synchroniser
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_latch_out_q   <= 1'b0;
      sync1_q             <= 1'b0;
      sync2_q             <= 1'b0;
      sync2_prev_q        <= 1'b0;
      start_pulse_level_q <= 1'b0;
    end
    else
    begin
      start_latch_out_q   <= start_button_level_i;
      sync1_q             <= start_latch_out_q & start_gating_qualifier_i;
      sync2_q             <= sync1_q;
      sync2_prev_q        <= sync2_q;
      start_pulse_level_q <= sync2_q & ~sync2_prev_q;
    end
  end

  // cycle sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cycle_phase_counter_q  <= `CMTPS_PH_IDLE;
      end_hold_q             <= 1'b0;
      start_record_flag_q    <= 1'b0;
      write_cycle_flag_q     <= 1'b0;
      worst_case_flag_q      <= 1'b0;
      advance_pending_q      <= 1'b0;
      word_address_counter_q <= {`CMTPS_ADDR_W{1'b0}};
      mem_start_o            <= 1'b0;
    end
    else
    begin
      mem_start_o <= cycle_start;
      if (!worst_sel && !cycle_start && ph == `CMTPS_PH_IDLE)
        worst_case_flag_q <= 1'b0;
      if (manual_mode)
        write_cycle_flag_q <= man_wr;
      if (cycle_start)
      begin
        cycle_phase_counter_q <= `CMTPS_PH_ONE;
        end_hold_q            <= 1'b0;
        start_record_flag_q   <= 1'b0;
        if (start_record_flag_q && advance_pending_q)
        begin
          advance_pending_q <= 1'b0;
          if (count_en)
            word_address_counter_q <= addr_d;
        end
      end
      else if (ph == `CMTPS_PH_ONE || ph == `CMTPS_PH_SAMPLE)
        cycle_phase_counter_q <= ph + 2'h1;
      else if (at_end)
      begin
        start_record_flag_q <= 1'b1;
        if (continue_enable)
          end_hold_q <= 1'b1;
        else
          cycle_phase_counter_q <= `CMTPS_PH_IDLE;
        if (manual_mode)
          advance_pending_q <= 1'b1;
        else if (write_cycle_flag_q && !worst_case_flag_q)
          advance_pending_q <= 1'b1;
        if (!manual_mode)
        begin
          write_cycle_flag_q <= ~write_cycle_flag_q;
          if (worst_sel && !write_cycle_flag_q)
            worst_case_flag_q <= ~worst_case_flag_q;
        end
      end
      else if (wb_ack_o && wb_we_i && wb_adr_i[4:2] == `CMTPS_REG_ADDR &&
               ph == `CMTPS_PH_IDLE)
      begin
        word_address_counter_q <= wb_dat_i[`CMTPS_ADDR_W-1:0];
        advance_pending_q      <= 1'b0;
      end
    end
  end

  // info hold register, error flag, control register and bus slave
  wire bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire [2:0] ri = wb_adr_i[4:2];
  wire sample   = (ph == `CMTPS_PH_SAMPLE) & ~write_now;
  wire load_pat = (ph == `CMTPS_PH_ONE) & ~manual_mode & write_cycle_flag_q;
  wire clr_info = at_end & ~write_now & ~stopped_err;
  wire [31:0] info_hi32 = {{(64-`CMTPS_DATA_W){1'b0}},
                           info_hold_register_q[`CMTPS_DATA_W-1:32]};
  wire [31:0] hi_new    = merge(info_hi32, wb_dat_i, wb_sel_i);
  wire [31:0] lo_new    = merge(info_hold_register_q[31:0], wb_dat_i, wb_sel_i);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q               <= `CMTPS_CTRL_RST;
      info_hold_register_q <= {`CMTPS_DATA_W{1'b0}};
      error_q              <= 1'b0;
      wb_ack_o             <= 1'b0;
      wb_dat_o             <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (bus_wr && ri == `CMTPS_REG_CTRL)
        ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
      if (sample)
        info_hold_register_q <= mem_rdata_i;
      else if (load_pat)
        info_hold_register_q <= pattern;
      else if (clr_info)
        info_hold_register_q <= {`CMTPS_DATA_W{1'b0}};
      else if (bus_wr && ri == `CMTPS_REG_INFO_LO)
        info_hold_register_q[31:0] <= lo_new;
      else if (bus_wr && ri == `CMTPS_REG_INFO_HI)
        info_hold_register_q[`CMTPS_DATA_W-1:32] <= hi_new[`CMTPS_DATA_W-33:0];
      if (sample && read_fault)
        error_q <= 1'b1;
      else if (clr_info)
        error_q <= 1'b0;
      else if (bus_wr && ri == `CMTPS_REG_STATUS && wb_sel_i[2] &&
               wb_dat_i[`CMTPS_SB_ERR])
        error_q <= 1'b0;
      case (ri)
        `CMTPS_REG_CTRL:    wb_dat_o <= ctrl_q;
        `CMTPS_REG_INFO_LO: wb_dat_o <= info_hold_register_q[31:0];
        `CMTPS_REG_INFO_HI: wb_dat_o <= info_hi32;
        `CMTPS_REG_STATUS:  wb_dat_o <= status_word(error_q, advance_pending_q,
                                                    worst_case_flag_q,
                                                    write_cycle_flag_q,
                                                    start_record_flag_q,
                                                    end_hold_q, ph,
                                                    word_address_counter_q);
        `CMTPS_REG_ADDR:    wb_dat_o <= {20'h0_0000, word_address_counter_q};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // memory side next values
  reg                       mem_write_d;
  reg  [`CMTPS_DATA_W-1:0]  mem_wdata_d;
  reg                       mem_wparity_d;
  always @*
  begin
    mem_write_d   = write_now;
    mem_wdata_d   = mem_rdata_i;
    mem_wparity_d = mem_rparity_i;
    if (write_now)
    begin
      mem_wdata_d   = info_hold_register_q;
      mem_wparity_d = parity(info_hold_register_q);
    end
  end

  // memory side outputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_write_o   <= 1'b0;
      mem_addr_o    <= {`CMTPS_ADDR_W{1'b0}};
      mem_wdata_o   <= {`CMTPS_DATA_W{1'b0}};
      mem_wparity_o <= `CMTPS_ODD_PARITY;
    end
    else
    begin
      mem_write_o   <= mem_write_d;
      mem_addr_o    <= addr_d;
      mem_wdata_o   <= mem_wdata_d;
      mem_wparity_o <= mem_wparity_d;
    end
  end

  assign busy_o = (ph != `CMTPS_PH_IDLE);

endmodule
`default_nettype wire

//--- cmtps_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cmtps_core_bench;
  localparam logic [47:0] RD = 48'h5a5a_0f0f_3c3c;
  localparam logic [47:0] ONES = 48'hffff_ffff_ffff;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = Z, wb_dat_o, rd;
  logic        wb_ack_o, btn, qual, ph6, rpar = 1'b1, mem_start_o, mem_write_o;
  logic        mem_wparity_o, busy_o, log_w [0:15];
  logic [11:0] mem_addr_o, log_a [0:15];
  logic [47:0] mem_wdata_o, log_d [0:15];
  logic [1:0]  sd_q = 2'h0;
  int          n_st = 0, fails = 0, total_checks = 0;
  bit          ok;
  always #20 clk_i = ~clk_i;
  cmtps_core u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .start_button_level_i(btn),
    .start_gating_qualifier_i(qual), .sixth_clock_phase_i(ph6), .mem_rdata_i(RD),
    .mem_rparity_i(rpar), .mem_start_o, .mem_write_o, .mem_addr_o, .mem_wdata_o,
    .mem_wparity_o, .busy_o);
  cmtps_panel u_panel (.clk_i, .busy_i(busy_o), .start_button_level_o(btn),
    .start_gating_qualifier_o(qual), .sixth_clock_phase_o(ph6));
  // log each cycle in its third phase
  always @(posedge clk_i)
  begin
    sd_q <= {sd_q[0], mem_start_o};
    if (rst_i)
      n_st <= 0;
    else if (sd_q[1])
    begin
      log_w[n_st[3:0]] <= mem_write_o;
      log_a[n_st[3:0]] <= mem_addr_o;
      log_d[n_st[3:0]] <= mem_wdata_o;
      n_st <= n_st + 1;
    end
  end
  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bail(input bit bad);
    if (bad)
    begin
      fails++;
      final_report();
    end
  endtask
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++)
      @(posedge clk_i);
    bail(wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rst_seq;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic push;
    u_panel.press(ok);
    bail(!ok);
  endtask
  task automatic t_single;
    rst_seq();
    chk("wpar", mem_wparity_o, 1'b1);
    wb(1'b0, 5'h00, Z);
    chk("ctrl", rd, 32'h0000_2040);
    wb(1'b0, 5'h14, Z);
    chk("unmapped", rd, Z);
    wb(1'b1, 5'h10, 32'h0000_0004);
    wb(1'b1, 5'h00, 32'h0000_2048);
    u_panel.set_qual(1'b0);
    u_panel.press(ok);
    chk("gated", ok, 1'b0);
    chk("gstarts", n_st, 0);
    u_panel.set_qual(1'b1);
    repeat (3) push();
    chk("starts", n_st, 3);
    chk("w0", log_w[0], 1'b0);
    chk("a0", log_a[0], 12'h004);
    chk("d0", log_d[0], RD);
    chk("w1", log_w[1], 1'b1);
    chk("a1", log_a[1], 12'h004);
    chk("d1", log_d[1], ONES);
    chk("a2", log_a[2], 12'h005);
    chk("idle", busy_o, 1'b0);
  endtask
  task automatic t_worst;
    int i;
    rst_seq();
    wb(1'b1, 5'h00, 32'h0000_2045);
    push();
    for (i = 0; i < 400 && n_st < 8; i++)
      @(posedge clk_i);
    bail(n_st < 8);
    wb(1'b1, 5'h00, 32'h0000_204d);
    repeat (8) @(posedge clk_i);
    chk("stop", busy_o, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      chk("wr", log_w[i], i % 2 == 1);
      chk("adr", log_a[i], i / 4);
      if (i % 2 == 1)
        chk("pat", log_d[i], (i % 4 == 1) ? ~ONES : ONES);
    end
  endtask
  task automatic t_manual;
    rst_seq();
    wb(1'b1, 5'h04, 32'h89ab_cdef);
    wb(1'b1, 5'h00, 32'h0000_604f);
    repeat (2) push();
    chk("mw", log_w[1], 1'b1);
    chk("ma", log_a[1], 12'h001);
    chk("md", log_d[1], 48'h0000_89ab_cdef);
    wb(1'b0, 5'h04, Z);
    chk("keep", rd, 32'h89ab_cdef);
    wb(1'b1, 5'h00, 32'h0000_205b);
    rpar <= ^RD;
    push();
    chk("rw", log_w[2], 1'b0);
    wb(1'b0, 5'h0c, Z);
    chk("err", rd[19], 1'b1);
    wb(1'b0, 5'h04, Z);
    chk("held", rd, RD[31:0]);
  endtask
  initial
  begin
    t_single();
    t_worst();
    t_manual();
    final_report();
  end
endmodule
`default_nettype wire

//--- cmtps_panel.sv
`timescale 1ns/1ps
`default_nettype none
module cmtps_panel (
  input  wire logic clk_i,
  input  wire logic busy_i,
  output var  logic start_button_level_o,
  output var  logic start_gating_qualifier_o,
  output wire logic sixth_clock_phase_o
);
  logic [2:0] ph_q = 3'h0;
  initial start_gating_qualifier_o = 1'b1;
  assign sixth_clock_phase_o = (ph_q == 3'h5);
  initial start_button_level_o = 1'b0;
  always @(posedge clk_i)
    ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
  task automatic set_qual(input bit v);
    start_gating_qualifier_o <= v;
    @(posedge clk_i);
  endtask
  // presses missing the phase are lost, so retry
  task automatic press(output bit ok);
    ok = 1'b0;
    repeat (8)
    begin
      if (!ok)
      begin
        start_button_level_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        start_button_level_o <= 1'b0;
        repeat (8) @(posedge clk_i) ok |= busy_i;
      end
    end
  endtask
endmodule
`default_nettype wire
